// >>> rtl/twsbp_pkg.sv
package twsbp_pkg;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CLK_NS       = 25;
  // Half of a serial clock period that this end produces as master.
  localparam int HALF_NS      = 5000;
  localparam int HALF_CYC     = (HALF_NS + CLK_NS - 1) / CLK_NS;
  // Least time the bus still counts as busy after a stop condition.
  localparam int BUS_FREE_NS  = 4700;
  localparam int BUS_FREE_CYC = (BUS_FREE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0] HALF_LAST = 8'(HALF_CYC - 1);
  localparam logic [7:0] FREE_LAST = 8'(BUS_FREE_CYC - 1);

  // ==========================================================================
  // Framing and reset values
  // ==========================================================================
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] ACK_SLOT  = 4'h9;
  localparam logic [1:0] LINE_IDLE = 2'h3;
  localparam logic [7:0] READ_FILL = 8'hff;

  // ==========================================================================
  // Commands, carriers and states
  // ==========================================================================
  typedef enum logic [1:0] {
    OP_START = 2'h0,
    OP_WRITE = 2'h1,
    OP_READ  = 2'h2,
    OP_STOP  = 2'h3
  } twsbp_op_t;

  typedef struct packed {
    twsbp_op_t  op;
    logic [7:0] data;
    logic       last;
  } twsbp_cmd_t;

  typedef struct packed {
    logic [7:0] data;
    logic       valid;
  } twsbp_byte_t;

  typedef enum logic [3:0] {
    M_IDLE  = 4'h0,
    M_START = 4'h1,
    M_HOLD  = 4'h2,
    M_LOW   = 4'h3,
    M_RISE  = 4'h4,
    M_HIGH  = 4'h5,
    M_RS1   = 4'h6,
    M_RS2   = 4'h7,
    M_STOP1 = 4'h8,
    M_STOP2 = 4'h9,
    M_STOP3 = 4'ha
  } twsbp_mst_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_ADDR = 3'h1,
    S_RX   = 3'h2,
    S_TX   = 3'h3,
    S_SKIP = 3'h4
  } twsbp_sst_t;

endpackage : twsbp_pkg

// >>> rtl/twsbp_sync.sv
`timescale 1ns/100ps
// Two-stage synchroniser for the bus lines; reset to the idle-high level.
module twsbp_sync (
  input  wire logic       clock,
  input  wire logic       srst,
  input  wire logic [1:0] din,
  output logic      [1:0] dout
);

  logic [1:0] meta_q;

  for (genvar i = 0; i < 2; i++) begin : g_bit
    always_ff @(posedge clock) begin
      if (srst) begin
        meta_q[i] <= twsbp_pkg::LINE_IDLE[i];
        dout[i]   <= twsbp_pkg::LINE_IDLE[i];
      end else begin
        meta_q[i] <= din[i];
        dout[i]   <= meta_q[i];
      end
    end
  end

endmodule : twsbp_sync

// >>> rtl/twsbp_engine.sv
`timescale 1ns/100ps
module twsbp_engine (
  input  wire logic                    clock,
  input  wire logic                    srst,
  input  wire logic                    scl_in,
  output logic                         scl_out,
  output logic                         scl_oe,
  input  wire logic                    serial_data_line_in,
  output logic                         serial_data_line_out,
  output logic                         serial_data_line_oe,
  input  wire logic                    slave_en,
  input  wire logic [6:0]              own_addr,
  input  wire twsbp_pkg::twsbp_cmd_t   cmd,
  input  wire logic                    cmd_valid,
  output logic                         cmd_ready,
  output twsbp_pkg::twsbp_byte_t       rd_byte,
  output logic                         nack,
  output logic                         abort,
  output logic                         master_act,
  output logic                         bus_busy,
  output twsbp_pkg::twsbp_byte_t       slv_rx,
  input  wire logic                    slv_rx_take,
  input  wire logic [7:0]              slv_tx_data,
  output logic                         slv_addressed,
  output logic                         slv_read
);

  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  function automatic logic is_ack(input logic [3:0] cnt);
    return cnt == twsbp_pkg::BYTE_BITS;
  endfunction : is_ack

  // ==========================================================================
  // Line sampling and bus condition detection
  // ==========================================================================
  logic [1:0] line_s;
  logic       scl_s, sda_s, scl_p_q, sda_p_q;
  logic       start_det, stop_det, rise, fall;
  logic       busy_d;
  logic [7:0] free_q, free_d;
  logic       stop_seen_q, stop_seen_d;

  twsbp_sync u_sync (
    .clock (clock),
    .srst  (srst),
    .din   ({scl_in, serial_data_line_in}),
    .dout  (line_s)
  );

  assign scl_s     = line_s[1];
  assign sda_s     = line_s[0];
  assign start_det = scl_s && scl_p_q && sda_p_q && !sda_s;
  assign stop_det  = scl_s && scl_p_q && !sda_p_q && sda_s;
  assign rise      = scl_s && !scl_p_q;
  assign fall      = !scl_s && scl_p_q;

  always_comb begin
    busy_d      = bus_busy;
    free_d      = free_q;
    stop_seen_d = stop_seen_q;
    if (start_det) begin
      busy_d      = 1'b1;
      stop_seen_d = 1'b0;
      free_d      = 8'h00;
    end else if (stop_det) begin
      stop_seen_d = 1'b1;
      free_d      = 8'h00;
    end else if (stop_seen_q) begin
      free_d = free_q + 8'h01;
      if (free_q == twsbp_pkg::FREE_LAST) begin
        busy_d      = 1'b0;
        stop_seen_d = 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      scl_p_q     <= 1'b1;
      sda_p_q     <= 1'b1;
      bus_busy    <= 1'b0;
      free_q      <= 8'h00;
      stop_seen_q <= 1'b0;
    end else begin
      scl_p_q     <= scl_s;
      sda_p_q     <= sda_s;
      bus_busy    <= busy_d;
      free_q      <= free_d;
      stop_seen_q <= stop_seen_d;
    end
  end

  // ==========================================================================
  // Master sequencer
  // ==========================================================================
  twsbp_pkg::twsbp_mst_t  m_st_q, m_st_d;
  twsbp_pkg::twsbp_byte_t rd_d;
  logic [7:0] qcnt_q, qcnt_d, m_sh_q, m_sh_d;
  logic [3:0] m_bit_q, m_bit_d;
  logic       m_rd_q, m_rd_d, m_last_q, m_last_d;
  logic       m_scl_lo_q, m_scl_lo_d, m_sda_lo_q, m_sda_lo_d;
  logic       nack_d, abort_d, master_d, ready_d, tick, take, lost;

  assign tick = qcnt_q == twsbp_pkg::HALF_LAST;
  assign take = cmd_valid && cmd_ready;
  // Data bits a slave sends during a read, and its acknowledge on a write,
  // are not ours to compare.
  assign lost = !m_sda_lo_q && !sda_s
             && !(m_rd_q && !is_ack(m_bit_q))
             && !(!m_rd_q && is_ack(m_bit_q));

  always_comb begin
    m_st_d     = m_st_q;
    m_sh_d     = m_sh_q;
    m_bit_d    = m_bit_q;
    m_rd_d     = m_rd_q;
    m_last_d   = m_last_q;
    m_scl_lo_d = m_scl_lo_q;
    m_sda_lo_d = m_sda_lo_q;
    rd_d       = rd_byte;
    rd_d.valid = 1'b0;
    nack_d     = nack;
    abort_d    = 1'b0;
    master_d   = master_act;
    qcnt_d     = qcnt_q + 8'h01;
    case (m_st_q)
      twsbp_pkg::M_IDLE: begin
        m_scl_lo_d = 1'b0;
        m_sda_lo_d = 1'b0;
        // Non-start commands taken here are dropped: no bus is owned yet.
        if (take && cmd.op == twsbp_pkg::OP_START) begin
          m_st_d = twsbp_pkg::M_START;
        end
      end
      twsbp_pkg::M_START: begin
        m_sda_lo_d = 1'b1;
        master_d   = 1'b1;
        if (tick) begin
          m_scl_lo_d = 1'b1;
          m_st_d     = twsbp_pkg::M_HOLD;
        end
      end
      twsbp_pkg::M_HOLD: begin
        if (take) begin
          m_bit_d = 4'h0;
          case (cmd.op)
            twsbp_pkg::OP_WRITE: begin
              m_sh_d = cmd.data;
              m_rd_d = 1'b0;
              m_st_d = twsbp_pkg::M_LOW;
            end
            twsbp_pkg::OP_READ: begin
              m_sh_d   = twsbp_pkg::READ_FILL;
              m_rd_d   = 1'b1;
              m_last_d = cmd.last;
              m_st_d   = twsbp_pkg::M_LOW;
            end
            twsbp_pkg::OP_START: m_st_d = twsbp_pkg::M_RS1;
            default:             m_st_d = twsbp_pkg::M_STOP1;
          endcase
        end
      end
      twsbp_pkg::M_LOW: begin
        m_scl_lo_d = 1'b1;
        if (is_ack(m_bit_q)) begin
          m_sda_lo_d = m_rd_q && !m_last_q;
        end else begin
          m_sda_lo_d = !m_rd_q && !m_sh_q[7];
        end
        if (tick) begin
          m_st_d = twsbp_pkg::M_RISE;
        end
      end
      twsbp_pkg::M_RISE: begin
        m_scl_lo_d = 1'b0;
        if (scl_s) begin
          m_st_d = twsbp_pkg::M_HIGH;
        end
      end
      twsbp_pkg::M_HIGH: begin
        if (start_det || stop_det || (tick && lost)) begin
          m_st_d     = twsbp_pkg::M_IDLE;
          m_scl_lo_d = 1'b0;
          m_sda_lo_d = 1'b0;
          master_d   = 1'b0;
          abort_d    = 1'b1;
        end else if (tick) begin
          m_scl_lo_d = 1'b1;
          if (is_ack(m_bit_q)) begin
            m_st_d = twsbp_pkg::M_HOLD;
            if (m_rd_q) begin
              rd_d = '{data: m_sh_q, valid: 1'b1};
            end else begin
              nack_d = sda_s;
            end
          end else begin
            m_sh_d  = {m_sh_q[6:0], sda_s};
            m_bit_d = m_bit_q + 4'h1;
            m_st_d  = twsbp_pkg::M_LOW;
          end
        end
      end
      twsbp_pkg::M_RS1: begin
        m_scl_lo_d = 1'b1;
        m_sda_lo_d = 1'b0;
        if (tick) begin
          m_st_d = twsbp_pkg::M_RS2;
        end
      end
      twsbp_pkg::M_RS2, twsbp_pkg::M_STOP2: begin
        m_scl_lo_d = 1'b0;
        if (!scl_s) begin
          qcnt_d = 8'h00;
        end else if (tick) begin
          m_st_d = (m_st_q == twsbp_pkg::M_RS2) ? twsbp_pkg::M_START
                                                 : twsbp_pkg::M_STOP3;
        end
      end
      twsbp_pkg::M_STOP1: begin
        m_scl_lo_d = 1'b1;
        m_sda_lo_d = 1'b1;
        if (tick) begin
          m_st_d = twsbp_pkg::M_STOP2;
        end
      end
      twsbp_pkg::M_STOP3: begin
        m_sda_lo_d = 1'b0;
        if (tick) begin
          m_st_d   = twsbp_pkg::M_IDLE;
          master_d = 1'b0;
        end
      end
      default: begin
        m_st_d     = twsbp_pkg::M_IDLE;
        m_scl_lo_d = 1'b0;
        m_sda_lo_d = 1'b0;
      end
    endcase
    if (m_st_d != m_st_q) begin
      qcnt_d = 8'h00;
    end
    ready_d = (m_st_d == twsbp_pkg::M_IDLE && !busy_d)
           || m_st_d == twsbp_pkg::M_HOLD;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      m_st_q     <= twsbp_pkg::M_IDLE;
      qcnt_q     <= 8'h00;
      m_sh_q     <= 8'h00;
      m_bit_q    <= 4'h0;
      m_rd_q     <= 1'b0;
      m_last_q   <= 1'b0;
      m_scl_lo_q <= 1'b0;
      m_sda_lo_q <= 1'b0;
      rd_byte    <= '0;
      nack       <= 1'b0;
      abort      <= 1'b0;
      master_act <= 1'b0;
      cmd_ready  <= 1'b0;
    end else begin
      m_st_q     <= m_st_d;
      qcnt_q     <= qcnt_d;
      m_sh_q     <= m_sh_d;
      m_bit_q    <= m_bit_d;
      m_rd_q     <= m_rd_d;
      m_last_q   <= m_last_d;
      m_scl_lo_q <= m_scl_lo_d;
      m_sda_lo_q <= m_sda_lo_d;
      rd_byte    <= rd_d;
      nack       <= nack_d;
      abort      <= abort_d;
      master_act <= master_d;
      cmd_ready  <= ready_d;
    end
  end

  // ==========================================================================
  // Slave responder
  // ==========================================================================
  twsbp_pkg::twsbp_sst_t  s_st_q, s_st_d;
  twsbp_pkg::twsbp_byte_t rx_d;
  logic [3:0] s_cnt_q, s_cnt_d;
  logic [7:0] s_sh_q, s_sh_d;
  logic       s_sda_lo_q, s_sda_lo_d, s_nk_q, s_nk_d, s_adr_d, s_rd_d;

  always_comb begin
    s_st_d     = s_st_q;
    s_cnt_d    = s_cnt_q;
    s_sh_d     = s_sh_q;
    s_sda_lo_d = s_sda_lo_q;
    s_nk_d     = s_nk_q;
    s_adr_d    = slv_addressed;
    s_rd_d     = slv_read;
    rx_d       = slv_rx;
    if (slv_rx_take) begin
      rx_d.valid = 1'b0;
    end
    if (start_det) begin
      s_st_d     = twsbp_pkg::S_ADDR;
      s_cnt_d    = 4'h0;
      s_sda_lo_d = 1'b0;
      s_adr_d    = 1'b0;
    end else if (stop_det) begin
      s_st_d     = twsbp_pkg::S_IDLE;
      s_sda_lo_d = 1'b0;
      s_adr_d    = 1'b0;
      rx_d.valid = 1'b0;
    end else if (s_st_q != twsbp_pkg::S_IDLE
              && s_st_q != twsbp_pkg::S_SKIP) begin
      if (rise) begin
        s_cnt_d = s_cnt_q + 4'h1;
        if (is_ack(s_cnt_q)) begin
          s_nk_d = sda_s;
        end else begin
          s_sh_d = {s_sh_q[6:0], sda_s};
        end
      end else if (fall) begin
        if (is_ack(s_cnt_q)) begin
          case (s_st_q)
            twsbp_pkg::S_ADDR: begin
              if (slave_en && !master_act && s_sh_q[7:1] == own_addr) begin
                s_sda_lo_d = 1'b1;
                s_adr_d    = 1'b1;
                s_rd_d     = s_sh_q[0];
              end else begin
                s_st_d = twsbp_pkg::S_SKIP;
              end
            end
            twsbp_pkg::S_RX: begin
              // An untaken byte is overwritten by the next one.
              rx_d       = '{data: s_sh_q, valid: 1'b1};
              s_sda_lo_d = 1'b1;
            end
            default: s_sda_lo_d = 1'b0;
          endcase
        end else if (s_cnt_q == twsbp_pkg::ACK_SLOT) begin
          s_cnt_d    = 4'h0;
          s_sda_lo_d = 1'b0;
          if (s_st_q == twsbp_pkg::S_RX
              || (s_st_q == twsbp_pkg::S_ADDR && !slv_read)) begin
            s_st_d = twsbp_pkg::S_RX;
          end else if (s_st_q == twsbp_pkg::S_TX && s_nk_q) begin
            s_st_d = twsbp_pkg::S_SKIP;
          end else begin
            s_st_d     = twsbp_pkg::S_TX;
            s_sh_d     = slv_tx_data;
            s_sda_lo_d = !slv_tx_data[7];
          end
        end else if (s_st_q == twsbp_pkg::S_TX) begin
          s_sda_lo_d = !s_sh_q[7];
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      s_st_q        <= twsbp_pkg::S_IDLE;
      s_cnt_q       <= 4'h0;
      s_sh_q        <= 8'h00;
      s_sda_lo_q    <= 1'b0;
      s_nk_q        <= 1'b0;
      slv_addressed <= 1'b0;
      slv_read      <= 1'b0;
      slv_rx        <= '0;
    end else begin
      s_st_q        <= s_st_d;
      s_cnt_q       <= s_cnt_d;
      s_sh_q        <= s_sh_d;
      s_sda_lo_q    <= s_sda_lo_d;
      s_nk_q        <= s_nk_d;
      slv_addressed <= s_adr_d;
      slv_read      <= s_rd_d;
      slv_rx        <= rx_d;
    end
  end

  // ==========================================================================
  // Open-drain pin drivers
  // ==========================================================================
  always_ff @(posedge clock) begin
    if (srst) begin
      scl_out              <= 1'b0;
      serial_data_line_out <= 1'b0;
      scl_oe               <= 1'b0;
      serial_data_line_oe  <= 1'b0;
    end else begin
      scl_out              <= 1'b0;
      serial_data_line_out <= 1'b0;
      scl_oe               <= m_scl_lo_q;
      serial_data_line_oe  <= m_sda_lo_q || s_sda_lo_q;
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  AST_OPEN_DRAIN: assert property (
    !scl_out && !serial_data_line_out)
    else $error("Bus line driven high.");
  AST_BUSY_ON_START: assert property (
    start_det |=> bus_busy)
    else $error("Bus not busy after start.");
  AST_RX_DROPPED: assert property (
    stop_det |=> !slv_rx.valid)
    else $error("Received byte still valid after stop.");
  AST_STRETCH_WAIT: assert property (
    (m_st_q == twsbp_pkg::M_RISE && !scl_s) |=> m_st_q != twsbp_pkg::M_HIGH)
    else $error("Master ran on while clock held low.");
  AST_SDA_STABLE: assert property (
    (m_st_q == twsbp_pkg::M_HIGH && $past(m_st_q) == twsbp_pkg::M_HIGH)
    |-> $stable(m_sda_lo_q))
    else $error("Master data moved during clock high.");
  AST_ACK_RELEASE: assert property (
    (m_st_q == twsbp_pkg::M_HIGH && is_ack(m_bit_q) && !m_rd_q)
    |-> !m_sda_lo_q)
    else $error("Master held data during slave acknowledge.");
  AST_READ_ACK: assert property (
    (m_st_q == twsbp_pkg::M_HIGH && is_ack(m_bit_q) && m_rd_q)
    |-> m_sda_lo_q == !m_last_q)
    else $error("Wrong master acknowledge level.");
  AST_ARB_LOSS: assert property (
    (m_st_q == twsbp_pkg::M_HIGH && tick && !m_sda_lo_q && !sda_s
     && !m_rd_q && !is_ack(m_bit_q) && !start_det && !stop_det)
    |=> (m_st_q == twsbp_pkg::M_IDLE && abort && !master_act))
    else $error("Lost arbitration not aborted.");
  AST_START_SHAPE: assert property (
    (m_st_q != twsbp_pkg::M_START ##1 m_st_q == twsbp_pkg::M_START)
    |=> (m_sda_lo_q && !m_scl_lo_q))
    else $error("Start not made with clock released.");
  AST_NINTH_PULSE: assert property (
    (m_st_q == twsbp_pkg::M_HIGH && tick && m_bit_q == 4'h7
     && !start_det && !stop_det && !lost)
    |=> m_st_q == twsbp_pkg::M_LOW && is_ack(m_bit_q))
    else $error("Acknowledge pulse skipped.");
  AST_SLAVE_ACK: assert property (
    (s_st_q == twsbp_pkg::S_RX && fall && is_ack(s_cnt_q)
     && !start_det && !stop_det)
    |=> (s_sda_lo_q && slv_rx.valid) ##1 serial_data_line_oe)
    else $error("Slave failed to acknowledge.");

endmodule : twsbp_engine

// >>> testbench/twsbp_slave_model.sv
`timescale 1ns/100ps
// ============================================================
// Slave on the shared lines
// ============================================================
// It only ever pulls a line low, so the pull-ups decide released levels.
module twsbp_slave_model #(
  parameter logic [6:0] ADDR = 7'h2a
) (
  input  wire logic scl,
  input  wire logic sda,
  input  wire logic stretch,
  output logic      sda_pull,
  output logic      scl_pull,
  output logic      mst_nack
);
  logic [7:0] sh;
  logic [7:0] tx;
  logic [7:0] got [$];
  int         bitn;
  logic       act;
  logic       sel;
  logic       rd;

  initial begin
    sda_pull = 1'b0;
    scl_pull = 1'b0;
    mst_nack = 1'b0;
    act      = 1'b0;
  end

  always @(negedge sda) if (scl === 1'b1) begin
    act      = 1'b1;
    bitn     = 0;
    sel      = 1'b0;
    rd       = 1'b0;
    mst_nack = 1'b0;
  end

  always @(posedge sda) if (scl === 1'b1) act = 1'b0;

  always @(posedge scl) if (act) begin
    if (bitn < 8) sh = {sh[6:0], sda};
    else if (rd) mst_nack = sda;
    bitn = bitn + 1;
  end

  // Data moves well after the clock fall, so it is never seen as a start.
  always @(negedge scl) if (act) begin
    #300;
    if (bitn == 8 && !rd) begin
      got.push_back(sh);
      if (!sel) begin
        sel = (sh[7:1] == ADDR);
        rd  = sh[0] && sel;
        tx  = 8'h4b;
      end
      sda_pull = sel;
    end else if (bitn == 9) begin
      rd = rd && !mst_nack;
      if (rd) tx = {tx[0], tx[7:1]};
      bitn = 0;
      sda_pull = rd && !tx[7];
    end else if (rd) begin
      sda_pull = (bitn < 8) && !tx[7 - bitn];
    end
    if (stretch) begin
      scl_pull = 1'b1;
      // Held past the master's own low half, so the master must wait.
      #8000 scl_pull = 1'b0;
    end
  end
endmodule : twsbp_slave_model

// >>> testbench/two_wire_serial_bus_protocol_bench.sv
`timescale 1ns/100ps
module two_wire_serial_bus_protocol_bench;
  localparam logic [6:0] SADDR = 7'h2a;
  logic                   clock = 1'b0;
  logic                   srst = 1'b1;
  logic                   scl_oe, sda_oe, scl_pull, sda_pull;
  logic                   stretch, mst_nack, cmd_valid, cmd_ready;
  logic                   nack, abort, master_act, bus_busy, seen_abort;
  logic [7:0]             got_rd;
  logic                   scl_grab, sda_grab, slave_en;
  logic                   slv_addressed, slv_read;
  logic [7:0]             slv_tx;
  twsbp_pkg::twsbp_byte_t slv_rx;
  twsbp_pkg::twsbp_cmd_t  cmd;
  twsbp_pkg::twsbp_byte_t rd_byte;
  int                     miscompares = 0;
  int                     total_checks = 0;
  wire                    scl = !(scl_oe || scl_pull || scl_grab);
  wire                    sda = !(sda_oe || sda_pull || sda_grab);

  always #12.5 clock = ~clock;

  twsbp_engine i_twsbp_engine (.clock(clock), .srst(srst), .scl_in(scl),
    .scl_out(), .scl_oe(scl_oe), .serial_data_line_in(sda),
    .serial_data_line_out(), .serial_data_line_oe(sda_oe),
    .slave_en(slave_en), .own_addr(7'h11), .cmd(cmd), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .rd_byte(rd_byte), .nack(nack), .abort(abort),
    .master_act(master_act), .bus_busy(bus_busy), .slv_rx(slv_rx),
    .slv_rx_take(1'b0), .slv_tx_data(slv_tx),
    .slv_addressed(slv_addressed), .slv_read(slv_read));

  twsbp_slave_model #(.ADDR(SADDR)) i_twsbp_slave_model (.scl(scl),
    .sda(sda), .stretch(stretch), .sda_pull(sda_pull),
    .scl_pull(scl_pull), .mst_nack(mst_nack));

  // ============================================================
  // Shared tasks
  // ============================================================
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Entered at a falling edge; returns once the engine is ready again.
  task automatic issue(input twsbp_pkg::twsbp_op_t op,
                       input logic [7:0] d, input logic last);
    int n;
    n = 0;
    cmd = '{op, d, last};
    cmd_valid = 1'b1;
    while (cmd_ready !== 1'b1) @(negedge clock);
    @(negedge clock);
    cmd_valid = 1'b0;
    while (cmd_ready !== 1'b1 && n < 40000) begin
      if (rd_byte.valid === 1'b1) got_rd = rd_byte.data;
      if (abort === 1'b1) seen_abort = 1'b1;
      n++;
      @(negedge clock);
    end
    // Read data comes with the same edge that raises ready again.
    if (rd_byte.valid === 1'b1) got_rd = rd_byte.data;
    if (n >= 40000) miscompares++;
  endtask : issue

  // The bench as a second master; every phase lasts 100 clock cycles, except the last phase of a stop, which lasts 250.
  task automatic bb_bit(input logic b, output logic s);
    sda_grab = !b;
    repeat (100) @(negedge clock);
    scl_grab = 1'b0;
    repeat (100) @(negedge clock);
    s = sda;
    scl_grab = 1'b1;
    repeat (100) @(negedge clock);
  endtask : bb_bit

  task automatic bb_byte(input logic [7:0] d, output logic [7:0] s,
                         output logic ack);
    for (int i = 7; i >= 0; i--) bb_bit(d[i], s[i]);
    bb_bit(1'b1, ack);
  endtask : bb_byte

  task automatic bb_start;
    sda_grab = 1'b0;
    repeat (100) @(negedge clock);
    scl_grab = 1'b0;
    repeat (100) @(negedge clock);
    sda_grab = 1'b1;
    repeat (100) @(negedge clock);
    scl_grab = 1'b1;
    repeat (100) @(negedge clock);
  endtask : bb_start

  task automatic bb_stop;
    sda_grab = 1'b1;
    repeat (100) @(negedge clock);
    scl_grab = 1'b0;
    repeat (100) @(negedge clock);
    sda_grab = 1'b0;
    repeat (250) @(negedge clock);
  endtask : bb_stop

  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : complete_run

  // ============================================================
  // Scenarios
  // ============================================================
  task automatic t_write;
    stretch = 1'b1;
    issue(twsbp_pkg::OP_START, 8'h00, 1'b0);
    check(bus_busy, 1'b1);
    check(master_act, 1'b1);
    issue(twsbp_pkg::OP_WRITE, {SADDR, 1'b0}, 1'b0);
    check(nack, 1'b0);
    issue(twsbp_pkg::OP_WRITE, 8'h96, 1'b0);
    check(nack, 1'b0);
    issue(twsbp_pkg::OP_STOP, 8'h00, 1'b0);
    check(bus_busy, 1'b0);
    check(master_act, 1'b0);
    check(i_twsbp_slave_model.got[0], {SADDR, 1'b0});
    check(i_twsbp_slave_model.got[1], 8'h96);
    stretch = 1'b0;
    $display("test write done");
  endtask : t_write

  task automatic t_read;
    issue(twsbp_pkg::OP_START, 8'h00, 1'b0);
    issue(twsbp_pkg::OP_WRITE, {SADDR, 1'b0}, 1'b0);
    issue(twsbp_pkg::OP_WRITE, 8'h11, 1'b0);
    issue(twsbp_pkg::OP_START, 8'h00, 1'b0);
    check(master_act, 1'b1);
    issue(twsbp_pkg::OP_WRITE, {SADDR, 1'b1}, 1'b0);
    check(nack, 1'b0);
    issue(twsbp_pkg::OP_READ, 8'h00, 1'b0);
    check(got_rd, 8'ha5);
    check(mst_nack, 1'b0);
    issue(twsbp_pkg::OP_READ, 8'h00, 1'b1);
    check(got_rd, 8'hd2);
    check(mst_nack, 1'b1);
    issue(twsbp_pkg::OP_STOP, 8'h00, 1'b0);
    check(i_twsbp_slave_model.got[3], 8'h11);
    check(master_act, 1'b0);
    $display("test read done");
  endtask : t_read

  task automatic t_nack;
    issue(twsbp_pkg::OP_START, 8'h00, 1'b0);
    issue(twsbp_pkg::OP_WRITE, {7'h2b, 1'b0}, 1'b0);
    check(nack, 1'b1);
    issue(twsbp_pkg::OP_STOP, 8'h00, 1'b0);
    check(bus_busy, 1'b0);
    $display("test nack done");
  endtask : t_nack

  // A byte command with no transaction open must not touch the bus.
  task automatic t_idle;
    issue(twsbp_pkg::OP_WRITE, 8'h55, 1'b0);
    repeat (500) @(negedge clock);
    check(master_act, 1'b0);
    check(8'(i_twsbp_slave_model.got.size()), 8'h06);
    check(seen_abort, 1'b0);
    $display("test idle done");
  endtask : t_idle

  // The engine as slave: one byte written to it, one byte read back.
  task automatic t_slave;
    logic [7:0] s;
    logic       a;
    slave_en = 1'b1;
    slv_tx = 8'h69;
    bb_start;
    bb_byte({7'h11, 1'b0}, s, a);
    check(a, 1'b0);
    check(slv_addressed, 1'b1);
    bb_byte(8'h3c, s, a);
    check(a, 1'b0);
    check(slv_rx.data, 8'h3c);
    check(slv_rx.valid, 1'b1);
    bb_start;
    bb_byte({7'h11, 1'b1}, s, a);
    check(a, 1'b0);
    check(slv_read, 1'b1);
    bb_byte(8'hff, s, a);
    check(s, 8'h69);
    bb_stop;
    check(slv_rx.valid, 1'b0);
    check(bus_busy, 1'b0);
    slave_en = 1'b0;
    $display("test slave done");
  endtask : t_slave

  // Data held low by another party while the engine sends ones.
  task automatic t_abort;
    issue(twsbp_pkg::OP_START, 8'h00, 1'b0);
    sda_grab = 1'b1;
    fork
      issue(twsbp_pkg::OP_WRITE, 8'hff, 1'b0);
      begin
        @(posedge abort);
        @(negedge clock);
        sda_grab = 1'b0;
      end
    join
    check(seen_abort, 1'b1);
    check(master_act, 1'b0);
    check(bus_busy, 1'b0);
    $display("test abort done");
  endtask : t_abort

  initial begin
    seen_abort = 1'b0;
    got_rd = 8'h00;
    stretch = 1'b0;
    scl_grab = 1'b0;
    sda_grab = 1'b0;
    slave_en = 1'b0;
    slv_tx = 8'h00;
    cmd_valid = 1'b0;
    cmd = '0;
    repeat (3) @(negedge clock);
    srst = 1'b0;
    t_write;
    t_read;
    t_nack;
    t_idle;
    t_slave;
    t_abort;
    complete_run;
  end

  // Scenarios need about 50000 cycles; this allows 80000.
  initial begin
    #2000000;
    miscompares++;
    complete_run;
  end
endmodule : two_wire_serial_bus_protocol_bench
